/* File: adcres_top.sv */
`include "adcres_params.svh"
module adcres_top #(
  parameter int NCH = 3
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire adcres_pkg::adcres_addr_type         paddr,
  input  wire adcres_pkg::adcres_word_type         pwdata,
  input  wire logic [3:0]                          pstrb,
  output adcres_pkg::adcres_word_type              prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [NCH-1:0]                      store_ch,
  input  wire adcres_pkg::adcres_result_type [NCH-1:0] store_data,
  output logic                                     irq
);
  import adcres_pkg::*;

  localparam int NEV = 2 * NCH;

  adcres_word_type prdata_r;
  adcres_word_type prdata_nxt;
  logic            slverr_r;
  logic            slverr_nxt;
  logic            setup;
  logic            setup_rd;
  logic            hit_status;
  logic            hit_mask;
  logic            hit_any;
  logic            wr_status;
  logic            wr_mask;
  logic [NCH-1:0]  hit_ch;
  logic [NCH-1:0]  ovr_ev;
  logic [NEV-1:0]  status;
  logic [NEV-1:0]  mask;
  adcres_word_type ch_word [NCH];
  adcres_result_type sel_value;
  adcres_result_type ch_value [NCH];

  adcres_ch_if ch_if [NCH] ();

  assign setup    = psel & ~penable;
  assign setup_rd = setup & ~pwrite;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      assign hit_ch[gi] = paddr == 12'(`ADCRES_OFF_CH5 + gi * `ADCRES_WORD_BYTES);
      assign ch_if[gi].store = store_ch[gi];
      assign ch_if[gi].data  = store_data[gi];
      // Flags clear at the edge where the word is captured for the read
      assign ch_if[gi].rd    = setup_rd & hit_ch[gi];
      assign ovr_ev[gi]      = ch_if[gi].ovr_event;
      // Plain copy so the read mux can index it with a loop variable
      assign ch_value[gi]    = ch_if[gi].value;

      always_comb
      begin
        ch_word[gi] = `ADCRES_WORD_RST;
        ch_word[gi][`ADCRES_HI_LSB +: 8] = ch_if[gi].value[9:2];
        ch_word[gi][`ADCRES_LO_LSB +: 2] = ch_if[gi].value[1:0];
        ch_word[gi][`ADCRES_OVR_BIT]     = ch_if[gi].overrun;
        ch_word[gi][`ADCRES_PRES_BIT]    = ch_if[gi].present;
      end

      adcres_channel u_ch (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (ch_if[gi])
      );
    end
  endgenerate

  assign hit_status = paddr == `ADCRES_OFF_STATUS;
  assign hit_mask   = paddr == `ADCRES_OFF_MASK;
  assign hit_any    = (|hit_ch) | hit_status | hit_mask;
  assign wr_status  = psel & penable & pwrite & hit_status & pstrb[0];
  assign wr_mask    = psel & penable & pwrite & hit_mask & pstrb[0];

  adcres_irq #(
    .NEV (NEV)
  ) u_irq (
    .pclk      (pclk),
    .presetn   (presetn),
    .events    ({ovr_ev, store_ch}),
    .wr_status (wr_status),
    .wr_mask   (wr_mask),
    .wdata     (pwdata[NEV-1:0]),
    .status    (status),
    .mask      (mask),
    .irq       (irq)
  );

  always_comb
  begin
    sel_value  = `ADCRES_RESULT_RST;
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    for (int i = 0; i < NCH; i++)
    begin
      if (hit_ch[i])
      begin
        sel_value = ch_value[i];
      end
    end
    if (setup)
    begin
      slverr_nxt = ~hit_any;
      prdata_nxt = `ADCRES_WORD_RST;
      if (!pwrite)
      begin
        for (int i = 0; i < NCH; i++)
        begin
          if (hit_ch[i])
          begin
            prdata_nxt = ch_word[i];
          end
        end
        if (hit_status)
        begin
          prdata_nxt[NEV-1:0] = status;
        end
        if (hit_mask)
        begin
          prdata_nxt[NEV-1:0] = mask;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= `ADCRES_WORD_RST;
      slverr_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = slverr_r & psel & penable;

  property p_upper_bits;
    @(posedge pclk) disable iff (!presetn)
    setup_rd && (|hit_ch) |=> prdata[15:8] == $past(sel_value[9:2]);
  endproperty
  a_upper_bits: assert property (p_upper_bits) else $error("upper result bits wrong");

  property p_lower_layout;
    @(posedge pclk) disable iff (!presetn)
    setup_rd && (|hit_ch) |=> prdata[7:6] == $past(sel_value[1:0])
      && prdata[5:2] == 4'h0 && prdata[31:16] == 16'h0000;
  endproperty
  a_lower_layout: assert property (p_lower_layout) else $error("lower result layout wrong");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    store_ch[0] && mask[0] && !wr_mask |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  c_read_ch: cover property (@(posedge pclk) disable iff (!presetn)
    setup_rd && (|hit_ch) ##1 prdata[`ADCRES_PRES_BIT]);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule

/* File: adcres_params.svh */
`ifndef ADCRES_PARAMS_SVH
`define ADCRES_PARAMS_SVH
`define ADCRES_ADDR_W        12
`define ADCRES_OFF_CH5       12'h000
`define ADCRES_WORD_BYTES    12'h004
`define ADCRES_OFF_STATUS    12'h00C
`define ADCRES_OFF_MASK      12'h010
`define ADCRES_HI_LSB        8
`define ADCRES_LO_LSB        6
`define ADCRES_OVR_BIT       1
`define ADCRES_PRES_BIT      0
`define ADCRES_ST_OVR_LSB    3
`define ADCRES_RESULT_RST    10'h000
`define ADCRES_WORD_RST      32'h0000_0000
`define ADCRES_IRQ_RST       6'h00
`endif

/* File: adcres_pkg.sv */
package adcres_pkg;
  typedef logic [9:0]  adcres_result_type;
  typedef logic [31:0] adcres_word_type;
  typedef logic [11:0] adcres_addr_type;
endpackage

/* File: adcres_ch_if.sv */
interface adcres_ch_if;
  import adcres_pkg::*;
  logic              store;
  adcres_result_type data;
  logic              rd;
  adcres_result_type value;
  logic              present;
  logic              overrun;
  logic              ovr_event;
  modport chan (input store, input data, input rd,
                output value, output present, output overrun, output ovr_event);
  modport host (output store, output data, output rd,
                input value, input present, input overrun, input ovr_event);
endinterface

/* File: adcres_channel.sv */
`include "adcres_params.svh"
module adcres_channel (
  input  wire logic  pclk,
  input  wire logic  presetn,
  adcres_ch_if.chan  ch
);
  import adcres_pkg::*;

  adcres_result_type value_r;
  adcres_result_type value_nxt;
  logic              present_r;
  logic              present_nxt;
  logic              overrun_r;
  logic              overrun_nxt;
  logic              ovr_set;

  always_comb
  begin
    value_nxt   = ch.store ? ch.data : value_r;
    // Store wins over a clearing read in the same cycle
    present_nxt = ch.store ? 1'b1 : (ch.rd ? 1'b0 : present_r);
    // A read in the same cycle returned the old value, so nothing was lost
    ovr_set     = ch.store & present_r & ~ch.rd;
    overrun_nxt = ovr_set ? 1'b1 : (ch.rd ? 1'b0 : overrun_r);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value_r   <= `ADCRES_RESULT_RST;
      present_r <= 1'b0;
      overrun_r <= 1'b0;
    end
    else
    begin
      value_r   <= value_nxt;
      present_r <= present_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  assign ch.value     = value_r;
  assign ch.present   = present_r;
  assign ch.overrun   = overrun_r;
  assign ch.ovr_event = ovr_set;

  property p_present_set;
    @(posedge pclk) disable iff (!presetn)
    ch.store |=> present_r && value_r == $past(ch.data);
  endproperty
  a_present_set: assert property (p_present_set) else $error("present not set on store");

  property p_present_clr;
    @(posedge pclk) disable iff (!presetn)
    ch.rd && !ch.store |=> !present_r;
  endproperty
  a_present_clr: assert property (p_present_clr) else $error("present not cleared by read");

  property p_overrun_set;
    @(posedge pclk) disable iff (!presetn)
    ch.store && present_r && !ch.rd |=> overrun_r ##1 (overrun_r || $past(ch.rd));
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged");

  property p_overrun_clr;
    @(posedge pclk) disable iff (!presetn)
    ch.rd |=> !overrun_r;
  endproperty
  a_overrun_clr: assert property (p_overrun_clr) else $error("overrun not cleared by read");

  property p_no_false_ovr;
    @(posedge pclk) disable iff (!presetn)
    !overrun_r && !(ch.store && present_r) |=> !overrun_r;
  endproperty
  a_no_false_ovr: assert property (p_no_false_ovr) else $error("spurious overrun");

  c_overrun: cover property (@(posedge pclk) disable iff (!presetn)
    ch.store ##1 ch.store ##1 ch.rd);
  c_same_cycle: cover property (@(posedge pclk) disable iff (!presetn)
    ch.store && ch.rd && present_r);
endmodule

/* File: adcres_irq.sv */
`include "adcres_params.svh"
module adcres_irq #(
  parameter int NEV = 6
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic [NEV-1:0] events,
  input  wire logic           wr_status,
  input  wire logic           wr_mask,
  input  wire logic [NEV-1:0] wdata,
  output logic      [NEV-1:0] status,
  output logic      [NEV-1:0] mask,
  output logic                irq
);
  logic [NEV-1:0] status_r;
  logic [NEV-1:0] status_nxt;
  logic [NEV-1:0] mask_r;
  logic [NEV-1:0] mask_nxt;

  always_comb
  begin
    // Write one to clear; a new event in the same cycle survives
    status_nxt = events | (status_r & ~(wr_status ? wdata : '0));
    mask_nxt   = wr_mask ? wdata : mask_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= NEV'(`ADCRES_IRQ_RST);
      mask_r   <= NEV'(`ADCRES_IRQ_RST);
    end
    else
    begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
    end
  end

  assign status = status_r;
  assign mask   = mask_r;
  assign irq    = |(status_r & mask_r);

  property p_event_sticky;
    @(posedge pclk) disable iff (!presetn)
    |events |=> (status_r & $past(events)) == $past(events);
  endproperty
  a_event_sticky: assert property (p_event_sticky) else $error("event lost against clear");
endmodule

/* File: adc_result_registers_tb_top.sv */
`include "adcres_params.svh"
`define CHK(got, exp) check_val(got, exp)
module adc_result_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adcres_pkg::*;

  logic                          pclk;
  logic                          presetn;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  adcres_addr_type               paddr;
  adcres_word_type               pwdata;
  logic [3:0]                    pstrb;
  adcres_word_type               prdata;
  logic                          pready;
  logic                          pslverr;
  logic [2:0]                    store_ch;
  adcres_result_type [2:0]       store_data;
  logic                          irq;
  adcres_word_type               rd_word;
  logic                          rd_err;
  adcres_result_type             vals [3];
  int                            num_errors;
  int                            cmp_count;
  int                            cycles;

  adcres_top #(.NCH(3)) dut_u (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pstrb      (pstrb),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .store_ch   (store_ch),
    .store_data (store_data),
    .irq        (irq)
  );

  always #10 pclk = ~pclk;

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard: the whole sequence needs about a hundred cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic check_val(input adcres_word_type got, input adcres_word_type exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  function automatic adcres_word_type rw(adcres_result_type v, logic o, logic p);
    return {16'h0000, v[9:2], v[1:0], 4'h0, o, p};
  endfunction

  function automatic adcres_addr_type ch_addr(int c);
    return `ADCRES_OFF_CH5 + `ADCRES_WORD_BYTES * 12'(c);
  endfunction

  // Leaves psel high so a following call runs back to back
  task automatic apb(input logic wr, input adcres_addr_type a, input adcres_word_type d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_word = prdata;
    rd_err = pslverr;
  endtask

  task automatic rd(input adcres_addr_type a, input adcres_word_type exp);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd_word, exp);
    `CHK(rd_err, 1'b0);
  endtask

  // Idle one cycle and look at the interrupt line
  task automatic irq_chk(input logic exp);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    `CHK(irq, exp);
  endtask

  task automatic store(input int c, input adcres_result_type v);
    psel <= 1'b0;
    penable <= 1'b0;
    store_ch <= 3'(1 << c);
    store_data[c] <= v;
    @(posedge pclk);
    store_ch <= 3'b000;
    @(posedge pclk);
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF; // Whole-word transfers only
    store_ch = 3'b000;
    store_data = '0;
    num_errors = 0;
    cmp_count = 0;
    cycles = 0;
    vals = '{10'h2D7, 10'h1A5, 10'h3C3};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int c = 0; c < 3; c++)
      rd(ch_addr(c), 32'h0000_0000);
    rd(`ADCRES_OFF_STATUS, 32'h0000_0000);
    rd(`ADCRES_OFF_MASK, 32'h0000_0000);
    irq_chk(1'b0);
    for (int c = 0; c < 3; c++)
    begin
      store(c, vals[c]);
      rd(ch_addr(c), rw(vals[c], 1'b0, 1'b1));
      rd(ch_addr(c), rw(vals[c], 1'b0, 1'b0));
    end
    // Result registers ignore writes
    apb(1'b1, ch_addr(0), 32'hFFFF_FFFF);
    rd(ch_addr(0), rw(vals[0], 1'b0, 1'b0));
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK(rd_err, 1'b1);
    `CHK(rd_word, 32'h0000_0000);
    for (int c = 0; c < 3; c++)
    begin
      store(c, 10'h155);
      store(c, vals[c]);
      rd(ch_addr(c), rw(vals[c], 1'b1, 1'b1));
      rd(ch_addr(c), rw(vals[c], 1'b0, 1'b0));
    end
    rd(`ADCRES_OFF_STATUS, 32'h0000_003F);
    irq_chk(1'b0);
    apb(1'b1, `ADCRES_OFF_MASK, 32'h0000_0008);
    irq_chk(1'b1);
    apb(1'b1, `ADCRES_OFF_STATUS, 32'h0000_0008);
    irq_chk(1'b0);
    rd(`ADCRES_OFF_STATUS, 32'h0000_0037);
    apb(1'b1, `ADCRES_OFF_MASK, 32'h0000_003F);
    irq_chk(1'b1);
    apb(1'b1, `ADCRES_OFF_STATUS, 32'h0000_003F);
    irq_chk(1'b0);
    rd(`ADCRES_OFF_STATUS, 32'h0000_0000);
    irq_chk(1'b0);
    // Store on the edge that takes a read: old word returned, new result kept unread
    store(0, 10'h0AA);
    fork
      apb(1'b0, ch_addr(0), 32'h0000_0000);
      begin
        store_ch <= 3'b001;
        store_data[0] <= vals[0];
        @(posedge pclk);
        store_ch <= 3'b000;
      end
    join
    `CHK(rd_word, rw(10'h0AA, 1'b0, 1'b1));
    rd(ch_addr(0), rw(vals[0], 1'b0, 1'b1));
    rd(ch_addr(0), rw(vals[0], 1'b0, 1'b0));
    irq_chk(1'b1);
    close_out();
  end
endmodule
